/* File: src/spi_mem_port.sv */
// Serial command front end of a small nonvolatile memory, plus its FIFO.
// Assumes the array core answers a read request within about 25 clk_sys
// cycles and raises busy_flag while a program or erase cycle runs.
`timescale 1ns/100ps

module spi_mem_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	// Filling side
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	// Draining side
	output logic      [WIDTH-1:0] outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wrPtr;
	logic [PW-1:0]    rdPtr;
	logic [PW:0]      count;
	logic             push;
	logic             pop;

	assign inReady  = (count != (PW+1)'(DEPTH));
	assign outValid = (count != '0);
	assign outData  = mem[rdPtr];
	assign push     = inValid & inReady;
	assign pop      = outValid & outReady;

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wrPtr] <= inData;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wrPtr <= (wrPtr == PW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
			end
			if (pop) begin
				rdPtr <= (rdPtr == PW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule

module spi_mem_port import spi_mem_pkg::*; (
	// Clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	// Serial pins
	input  wire logic              selectN,
	input  wire logic              serialClk,
	input  wire logic              serial_in,
	input  wire logic              pauseN,
	output logic                   serial_out,
	output logic                   serialOutEn,
	// Array core read port
	output logic      [ADDR_W-1:0] memAddr,
	output logic                   memRdReq,
	input  wire logic [DATA_W-1:0] memRdData,
	input  wire logic              memRdValid,
	// Array core program and erase control
	output logic                   startProg,
	output logic                   startPageErase,
	output logic                   startChipErase,
	input  wire logic              busy_flag,
	// Program data stream
	output logic      [DATA_W-1:0] progData,
	output logic                   progValid,
	input  wire logic              progReady,
	// Observed state
	output logic                   modify_enable_latch,
	output logic                   sleeping,
	output logic                   progOverrun
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [SYNC_STAGES-1:0] csSync;
	logic [SYNC_STAGES-1:0] sckSync;
	logic [SYNC_STAGES-1:0] dinSync;
	logic [SYNC_STAGES-1:0] holdSync;
	logic                   csLvl;
	logic                   sckLvl;
	logic                   dinLvl;
	logic                   holdLvl;
	logic                   csPrev;
	logic                   sckPrev;

	// A level only moves once the second and third stages agree
	function automatic logic settle(input logic [SYNC_STAGES-1:0] s,
	                                input logic cur);
		settle = (s[1] == s[2]) ? s[2] : cur;
	endfunction

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			csSync   <= '1;
			sckSync  <= '0;
			dinSync  <= '0;
			holdSync <= '1;
			csLvl    <= 1'b1;
			sckLvl   <= 1'b0;
			dinLvl   <= 1'b0;
			holdLvl  <= 1'b1;
			csPrev   <= 1'b1;
			sckPrev  <= 1'b0;
		end else begin
			csSync   <= {csSync[1:0], selectN};
			sckSync  <= {sckSync[1:0], serialClk};
			dinSync  <= {dinSync[1:0], serial_in};
			holdSync <= {holdSync[1:0], pauseN};
			csLvl    <= settle(csSync, csLvl);
			sckLvl   <= settle(sckSync, sckLvl);
			dinLvl   <= settle(dinSync, dinLvl);
			holdLvl  <= settle(holdSync, holdLvl);
			csPrev   <= csLvl;
			sckPrev  <= sckLvl;
		end
	end

	// ****************************************
	// Edge detection
	// ****************************************
	logic selected;
	logic live;
	logic sckRise;
	logic sckFall;
	logic csRise;

	assign selected = ~csLvl;
	assign live     = selected & holdLvl;
	// Either idle level works since only edges while selected count
	assign sckRise  = live & sckLvl & ~sckPrev;
	assign sckFall  = live & ~sckLvl & sckPrev;
	assign csRise   = csLvl & ~csPrev;

	// ****************************************
	// Receive shifter
	// ****************************************
	logic [7:0] rxShift;
	logic [2:0] bitCnt;
	logic [7:0] rxByte;
	logic       byteDone;

	assign rxByte   = {rxShift[6:0], dinLvl};
	assign byteDone = sckRise & (bitCnt == BIT_LAST);

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rxShift <= '0;
			bitCnt  <= '0;
		end else if (!selected) begin
			bitCnt <= '0;
		end else if (sckRise) begin
			rxShift <= rxByte;
			bitCnt  <= bitCnt + 1'b1;
		end
	end

	// ****************************************
	// Command sequencer
	// ****************************************
	port_state_t state;
	port_state_t next_state;
	logic [7:0]  opcode;
	logic        addrHigh;
	logic        haveData;
	logic        accepted;

	// Sleep admits only wake; busy admits only status read
	assign accepted = sleeping ? 1'b0 :
	                  (!busy_flag || rxByte == OP_STATE_READ);

	always_comb begin
		next_state = state;
		if (byteDone) begin
			case (state)
				ST_CMD: begin
					if (!accepted) begin
						next_state = ST_IGNORE;
					end else begin
						case (rxByte)
							OP_READ, OP_FAST_FETCH: next_state = ST_ADDR;
							OP_PROG, OP_PAGE_ERASE: begin
								next_state = modify_enable_latch ?
								             ST_ADDR : ST_IGNORE;
							end
							OP_STATE_READ: next_state = ST_STATUS;
							OP_LATCH_CLR, OP_LATCH_SET, OP_CHIP_ERA_A,
							OP_CHIP_ERA_B, OP_SLEEP: next_state = ST_TAIL;
							default: next_state = ST_IGNORE;
						endcase
					end
				end
				ST_ADDR: begin
					if (addrHigh) begin
						case (opcode)
							OP_READ:       next_state = ST_RDATA;
							OP_FAST_FETCH: next_state = ST_DUMMY;
							OP_PROG:       next_state = ST_WDATA;
							default:       next_state = ST_TAIL;
						endcase
					end
				end
				ST_DUMMY: next_state = ST_RDATA;
				default:  next_state = state;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state    <= ST_CMD;
			opcode   <= '0;
			addrHigh <= 1'b0;
		end else if (!selected) begin
			state    <= ST_CMD;
			addrHigh <= 1'b0;
		end else begin
			state <= next_state;
			if (byteDone && state == ST_CMD) begin
				opcode <= rxByte;
			end
			if (byteDone && state == ST_ADDR) begin
				addrHigh <= 1'b1;
			end
		end
	end

	// ****************************************
	// Address counter and read requests
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			memAddr  <= '0;
			memRdReq <= 1'b0;
		end else begin
			memRdReq <= 1'b0;
			if (byteDone && state == ST_ADDR) begin
				if (!addrHigh) begin
					// Upper three address bits are dropped
					memAddr[ADDR_W-1:8] <= rxByte[ADDR_W-9:0];
				end else begin
					memAddr[7:0] <= rxByte;
					memRdReq     <= (opcode == OP_READ) ||
					                (opcode == OP_FAST_FETCH);
				end
			end else if (byteDone && state == ST_RDATA) begin
				memAddr  <= memAddr + 1'b1;
				memRdReq <= 1'b1;
			end
		end
	end

	// ****************************************
	// Transmit shifter
	// ****************************************
	logic [7:0] dataBuf;
	logic [7:0] statusByte;
	logic [7:0] txSrc;
	logic [7:0] txShift;
	logic       loadPend;

	always_comb begin
		statusByte                 = STAT_RESET;
		statusByte[STAT_BUSY_BIT]  = busy_flag;
		statusByte[STAT_LATCH_BIT] = modify_enable_latch;
	end

	assign txSrc = (state == ST_STATUS) ? statusByte : dataBuf;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			dataBuf <= '0;
		end else if (memRdValid) begin
			dataBuf <= memRdData;
		end
	end

	// The byte is taken at the first falling edge, not at the byte
	// boundary, so the core has half a serial period to answer
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			loadPend   <= 1'b0;
			txShift    <= '0;
			serial_out <= 1'b0;
		end else if (!selected) begin
			loadPend <= 1'b0;
		end else begin
			if (byteDone && (next_state == ST_RDATA ||
			                 next_state == ST_STATUS)) begin
				loadPend <= 1'b1;
			end else if (sckFall) begin
				loadPend <= 1'b0;
			end
			if (sckFall) begin
				if (loadPend) begin
					serial_out <= txSrc[7];
					txShift    <= {txSrc[6:0], 1'b0};
				end else begin
					serial_out <= txShift[7];
					txShift    <= {txShift[6:0], 1'b0};
				end
			end
		end
	end

	assign serialOutEn = live &&
	                     (state == ST_RDATA || state == ST_STATUS);

	// ****************************************
	// Program data path
	// ****************************************
	logic [7:0] pendByte;
	logic       pendValid;
	logic       fifoInReady;

	// Bytes cannot be held back on the wire, so a byte that finds the
	// previous one still waiting marks the whole program as spoiled
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pendByte    <= '0;
			pendValid   <= 1'b0;
			haveData    <= 1'b0;
			progOverrun <= 1'b0;
		end else begin
			if (byteDone && state == ST_WDATA) begin
				pendByte  <= rxByte;
				pendValid <= 1'b1;
				haveData  <= 1'b1;
				if (pendValid && !fifoInReady) begin
					progOverrun <= 1'b1;
				end
			end else if (fifoInReady) begin
				pendValid <= 1'b0;
			end
			// Only the falling edge of select starts a fresh frame
			if (selected && csPrev) begin
				haveData    <= 1'b0;
				progOverrun <= 1'b0;
			end
		end
	end

	spi_mem_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.inData   (pendByte),
		.inValid  (pendValid),
		.inReady  (fifoInReady),
		.outData  (progData),
		.outValid (progValid),
		.outReady (progReady)
	);

	// ****************************************
	// Latch, sleep and execution on deselect
	// ****************************************
	logic wholeBytes;

	assign wholeBytes = csRise && (bitCnt == '0);

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			modify_enable_latch <= LATCH_RESET;
			sleeping            <= 1'b0;
			startProg           <= 1'b0;
			startPageErase      <= 1'b0;
			startChipErase      <= 1'b0;
		end else begin
			startProg      <= 1'b0;
			startPageErase <= 1'b0;
			startChipErase <= 1'b0;
			if (byteDone && state == ST_CMD && sleeping &&
			    rxByte == OP_WAKE) begin
				sleeping <= 1'b0;
			end
			if (wholeBytes && state == ST_TAIL) begin
				case (opcode)
					OP_LATCH_CLR: modify_enable_latch <= 1'b0;
					OP_LATCH_SET: modify_enable_latch <= 1'b1;
					OP_SLEEP: begin
						modify_enable_latch <= 1'b0;
						sleeping            <= 1'b1;
					end
					OP_PAGE_ERASE: begin
						startPageErase      <= modify_enable_latch;
						modify_enable_latch <= 1'b0;
					end
					OP_CHIP_ERA_A, OP_CHIP_ERA_B: begin
						if (modify_enable_latch) begin
							startChipErase      <= 1'b1;
							modify_enable_latch <= 1'b0;
						end
					end
					default: modify_enable_latch <= modify_enable_latch;
				endcase
			end else if (wholeBytes && state == ST_WDATA && haveData &&
			             !progOverrun) begin
				startProg           <= modify_enable_latch;
				modify_enable_latch <= 1'b0;
			end
		end
	end

endmodule

/* File: src/spi_mem_pkg.sv */
// Constants, opcodes and states shared by the serial memory command port.
// Assumes a single 100 MHz system clock; the serial clock is only sampled.
package spi_mem_pkg;

	// ****************************************
	// Opcodes, most significant bit first
	// ****************************************
	localparam logic [7:0] OP_PROG       = 8'h02;
	localparam logic [7:0] OP_READ       = 8'h03;
	localparam logic [7:0] OP_FAST_FETCH = 8'h0B;
	localparam logic [7:0] OP_LATCH_CLR  = 8'h04;
	localparam logic [7:0] OP_STATE_READ = 8'h05;
	localparam logic [7:0] OP_LATCH_SET  = 8'h06;
	localparam logic [7:0] OP_PAGE_ERASE = 8'h42;
	localparam logic [7:0] OP_CHIP_ERA_A = 8'h60;
	localparam logic [7:0] OP_CHIP_ERA_B = 8'hC7;
	localparam logic [7:0] OP_SLEEP      = 8'hB9;
	localparam logic [7:0] OP_WAKE       = 8'hAB;

	// ****************************************
	// Status register layout
	// ****************************************
	localparam int         STAT_BUSY_BIT  = 0;
	localparam int         STAT_LATCH_BIT = 1;
	localparam logic [7:0] STAT_RESET     = 8'h00;

	// ****************************************
	// Sizes and reset values
	// ****************************************
	localparam int          ADDR_W       = 13;
	localparam int          DATA_W       = 8;
	localparam int          FIFO_DEPTH   = 16;
	localparam int          SYNC_STAGES  = 3;
	localparam logic [2:0]  BIT_LAST     = 3'h7;
	localparam logic        LATCH_RESET  = 1'b0;

	typedef enum logic [2:0] {
		ST_CMD    = 3'b000,
		ST_ADDR   = 3'b001,
		ST_DUMMY  = 3'b010,
		ST_RDATA  = 3'b011,
		ST_STATUS = 3'b100,
		ST_WDATA  = 3'b101,
		ST_TAIL   = 3'b110,
		ST_IGNORE = 3'b111
	} port_state_t;

endpackage

/* File: dv/spi_mem_port_sva.sv */
// Checker for the serial memory command port, top ports only.
// Assumes one clk_sys domain with synchronous active-low rst_n.
`timescale 1ns/100ps
module spi_mem_port_sva import spi_mem_pkg::*; (
	// Clock and reset
	input wire logic              clk_sys,
	input wire logic              rst_n,
	// Serial pins
	input wire logic              selectN,
	input wire logic              serialClk,
	input wire logic              pauseN,
	input wire logic              serial_out,
	input wire logic              serialOutEn,
	// Core side
	input wire logic [ADDR_W-1:0] memAddr,
	input wire logic              memRdReq,
	input wire logic              startProg,
	input wire logic              startPageErase,
	input wire logic              startChipErase,
	input wire logic              busy_flag,
	input wire logic              modify_enable_latch
);
	logic anyStart;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	assign anyStart = startProg | startPageErase | startChipErase;

	// ****************************************
	// Assertions
	// ****************************************
	idle_quiet_a: assert property (selectN [*8] |-> !serialOutEn)
		else $error("output driven while deselected");
	pause_quiet_a: assert property (!pauseN [*8] |-> !serialOutEn)
		else $error("output driven while paused");
	out_edge_a: assert property ($changed(serial_out) && serialOutEn
		|-> !$past(serialClk, 2)) else $error("output moved off a fall");
	start_latch_a: assert property (startChipErase
		|-> $past(modify_enable_latch)) else $error("erase without latch");
	start_clear_a: assert property (anyStart
		|-> !modify_enable_latch) else $error("latch kept after start");
	start_desel_a: assert property (anyStart
		|-> selectN && $past(selectN, 3)) else $error("start while selected");
	start_idle_a: assert property (anyStart
		|-> !$past(busy_flag)) else $error("start while busy");
	latch_rise_a: assert property ($rose(modify_enable_latch)
		|-> $past(selectN, 3)) else $error("latch set mid-frame");
	rdreq_sel_a: assert property (memRdReq
		|-> !$past(selectN, 4) ##1 !memRdReq) else $error("bad read request");
	addr_inc_a: assert property ($changed(memAddr) && !selectN
		&& $past(serialOutEn) |-> memAddr == $past(memAddr) + 13'h0001)
		else $error("read address not advanced by one");
endmodule

bind spi_mem_port spi_mem_port_sva chk_u (
	.clk_sys(clk_sys), .rst_n(rst_n), .selectN(selectN),
	.serialClk(serialClk), .pauseN(pauseN), .serial_out(serial_out),
	.serialOutEn(serialOutEn), .memAddr(memAddr), .memRdReq(memRdReq),
	.startProg(startProg), .startPageErase(startPageErase),
	.startChipErase(startChipErase), .busy_flag(busy_flag),
	.modify_enable_latch(modify_enable_latch)
);

/* File: dv/spi_master_model.sv */
// Serial master on the far side of the port, modes 0 and 3.
// Assumes its tasks are called from one bench process at a time.
`timescale 1ns/100ps
module spi_master_model (
	// Clock
	input  wire logic clk_sys,
	// Pins
	output logic      selectN,
	output logic      serialClk,
	output logic      serial_in,
	output logic      pauseN,
	input  wire logic serial_out
);
	logic mode3;
	logic pauseAt;

	initial begin
		selectN = 1'b1;
		serialClk = 1'b0;
		serial_in = 1'b0;
		pauseN = 1'b1;
		mode3 = 1'b0;
		pauseAt = 1'b0;
	end

	// ****************************************
	// Frame tasks
	// ****************************************
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// Idle level only moves while deselected
	task automatic setMode(input logic m);
		mode3 = m;
		serialClk <= m;
		tick(20);
	endtask

	task automatic sel();
		selectN <= 1'b0;
		tick(8);
	endtask

	// Data set while clock low, taken at the rise, half period 8 cycles
	task automatic xb(input logic [7:0] tx, output logic [7:0] rx,
		input int n);
		for (int i = 7; i > 7 - n; i--) begin
			serialClk <= 1'b0;
			serial_in <= tx[i];
			tick(8);
			// Pause only after the fall is seen, so that bit still launches
			if (pauseAt && i == 3) begin
				pauseN <= 1'b0;
				tick(8);
				serialClk <= 1'b1;
				tick(8);
				serialClk <= 1'b0;
				tick(8);
				pauseN <= 1'b1;
				tick(8);
			end
			serialClk <= 1'b1;
			rx[i] = serial_out;
			tick(8);
		end
	endtask

	task automatic desel();
		if (!mode3) begin
			serialClk <= 1'b0;
			tick(8);
		end
		selectN <= 1'b1;
		// Released line must not keep its last level
		serial_in <= ~serial_in;
		tick(24);
	endtask
endmodule

/* File: dv/spi_serial_memory_command_port_tb.sv */
// Self-checking bench for the serial memory command port.
// Assumes a behavioural array core here and a master model on the pins.
`timescale 1ns/100ps
module spi_serial_memory_command_port_tb import spi_mem_pkg::*;;
	logic              clk_sys = 1'b0;
	logic              rst_n;
	logic              selectN, serialClk, serial_in, pauseN;
	logic              serial_out, serialOutEn, memRdReq, progValid;
	logic              startProg, startPageErase, startChipErase;
	logic              memRdValid = 1'b0;
	logic              busy_flag = 1'b0;
	logic              progReady = 1'b0;
	logic              stall = 1'b0;
	logic              modify_enable_latch, sleeping, progOverrun;
	logic [ADDR_W-1:0] memAddr, rdA;
	logic [7:0]        memRdData = 8'h00;
	logic [7:0]        progData, r;
	logic [7:0]        pq [$];
	logic [7:0]        mods [4] = '{OP_CHIP_ERA_A, OP_CHIP_ERA_B,
		OP_PAGE_ERASE, OP_PROG};
	logic [31:0]       rs = 32'h0000_8882;
	logic [31:0]       rp = 32'h0000_8882;
	logic              latExp = 1'b0;
	logic              sleepExp = 1'b0;
	logic              bz;
	int                nFail = 0;
	int                nCompared = 0;
	int                nStart = 0;
	int                nStartExp = 0;
	int                rdCnt = 0;
	int                busyCnt = 0;
	int                cyc = 0;
	wire               outPin = serialOutEn ? serial_out : 1'bz;

	always #5 clk_sys = ~clk_sys;

	spi_mem_port dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
		.selectN(selectN), .serialClk(serialClk), .serial_in(serial_in),
		.pauseN(pauseN), .serial_out(serial_out), .serialOutEn(serialOutEn),
		.memAddr(memAddr), .memRdReq(memRdReq), .memRdData(memRdData),
		.memRdValid(memRdValid), .startProg(startProg),
		.startPageErase(startPageErase), .startChipErase(startChipErase),
		.busy_flag(busy_flag), .progData(progData), .progValid(progValid),
		.progReady(progReady), .modify_enable_latch(modify_enable_latch),
		.sleeping(sleeping), .progOverrun(progOverrun));

	spi_master_model mst (.clk_sys(clk_sys), .selectN(selectN),
		.serialClk(serialClk), .serial_in(serial_in), .pauseN(pauseN),
		.serial_out(outPin));

	// ****************************************
	// Helpers and checks
	// ****************************************
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	function automatic logic [7:0] mb(input logic [12:0] a);
		return a[7:0] ^ {a[12:8], 3'h5};
	endfunction

	task automatic chkByte(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		nCompared++;
		if (g !== e) begin
			nFail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chkLvl(input string nm, input logic e, input logic g);
		nCompared++;
		if (g !== e) begin
			nFail++;
			$display("[ERR] %s expected %b seen %b", nm, e, g);
		end
	endtask

	task automatic chkCnt(input string nm, input int e, input int g);
		nCompared++;
		if (g != e) begin
			nFail++;
			$display("[ERR] %s expected %0d seen %0d", nm, e, g);
		end
	endtask

	task automatic testDone();
		$display("compared %0d failed %0d", nCompared, nFail);
		if (nFail == 0 && nCompared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Reference model of latch, sleep and start decisions
	task automatic mdl(input logic [7:0] op);
		if (sleepExp) begin
			sleepExp = (op != OP_WAKE);
		end else if (!bz) begin
			case (op)
				OP_LATCH_SET: latExp = 1'b1;
				OP_LATCH_CLR: latExp = 1'b0;
				OP_SLEEP: begin
					latExp = 1'b0;
					sleepExp = 1'b1;
				end
				OP_PROG, OP_PAGE_ERASE, OP_CHIP_ERA_A, OP_CHIP_ERA_B: begin
					nStartExp += latExp;
					latExp = 1'b0;
				end
				default: ;
			endcase
		end
	endtask

	task automatic open();
		bz = busy_flag;
		mst.sel();
	endtask

	task automatic close(input logic [7:0] op);
		mst.desel();
		mdl(op);
		chkLvl("latch", latExp, modify_enable_latch);
		chkLvl("sleeping", sleepExp, sleeping);
		chkLvl("overrun", 1'b0, progOverrun);
		chkCnt("starts", nStartExp, nStart);
	endtask

	task automatic mod(input logic [7:0] op, input int nd);
		open();
		mst.xb(op, r, 8);
		if (op == OP_PAGE_ERASE || op == OP_PROG) begin
			rs = xs(rs);
			mst.xb({3'h0, rs[12:8]}, r, 8);
			mst.xb(rs[7:0], r, 8);
		end
		repeat (nd) begin
			rs = xs(rs);
			pq.push_back(rs[7:0]);
			mst.xb(rs[7:0], r, 8);
		end
		close(op);
	endtask

	task automatic rdStat(input int n);
		open();
		mst.xb(OP_STATE_READ, r, 8);
		repeat (n) begin
			mst.xb(8'h00, r, 8);
			chkByte("status", {6'h00, latExp, bz}, r);
		end
		close(OP_STATE_READ);
	endtask

	task automatic rdMem(input logic [7:0] op, input logic [12:0] a,
		input int n);
		open();
		mst.xb(op, r, 8);
		mst.xb({3'h0, a[12:8]}, r, 8);
		mst.xb(a[7:0], r, 8);
		if (op == OP_FAST_FETCH) mst.xb(8'h5A, r, 8);
		repeat (n) begin
			rs = xs(rs);
			mst.xb(rs[7:0], r, 8);
			chkByte("read", mb(a), r);
			a = a + 13'h0001;
		end
		close(op);
	endtask

	task automatic waitIdle();
		for (int k = 0; k < 3000 && busy_flag; k++) @(posedge clk_sys);
	endtask

	// ****************************************
	// Array core, start counter and timeout
	// ****************************************
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		rp = xs(rp);
		progReady <= !stall && rp[0];
		memRdValid <= (rdCnt == 1);
		memRdData <= mb(rdA);
		if (memRdReq) begin
			rdCnt <= 3;
			rdA <= memAddr;
		end else if (rdCnt != 0) begin
			rdCnt <= rdCnt - 1;
		end
		if (startProg || startPageErase || startChipErase) begin
			nStart++;
			busyCnt <= 1500;
		end else if (busyCnt != 0) begin
			busyCnt <= busyCnt - 1;
		end
		busy_flag <= (busyCnt > 1);
		if (progValid && progReady) begin
			chkByte("prog data", pq.pop_front(), progData);
		end
		if (cyc == 60000) begin
			nFail++;
			testDone();
		end
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		rst_n = 1'b0;
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk_sys);
		rdStat(1);
		mod(OP_LATCH_SET, 0);
		rdStat(2);
		open();
		mst.xb(OP_LATCH_CLR, r, 5);
		close(8'h00);
		open();
		mst.xb(8'hFF, r, 8);
		mst.xb(OP_LATCH_CLR, r, 8);
		close(8'h00);
		mod(OP_LATCH_CLR, 0);
		mod(OP_PAGE_ERASE, 0);
		mod(OP_CHIP_ERA_A, 0);
		foreach (mods[i]) begin
			mod(OP_LATCH_SET, 0);
			stall <= 1'b1;
			mod(mods[i], (mods[i] == OP_PROG) ? 16 : 0);
			stall <= 1'b0;
			rdStat(1);
			mod(OP_LATCH_SET, 0);
			waitIdle();
			chkCnt("fifo left", 0, pq.size());
		end
		rdMem(OP_READ, 13'h1FFE, 3);
		mst.setMode(1'b1);
		rs = xs(rs);
		rdMem(OP_FAST_FETCH, rs[12:0], 2);
		// A nonzero status byte makes a lost shift under pause visible
		mod(OP_LATCH_SET, 0);
		mst.pauseAt = 1'b1;
		rdStat(1);
		mst.pauseAt = 1'b0;
		mod(OP_SLEEP, 0);
		mod(OP_LATCH_SET, 0);
		mod(OP_WAKE, 0);
		testDone();
	end
endmodule
